/* pcp_pkg.sv */
// Package with register map, reset values and field layout of the pad control
package pcp_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int STRB_W   = 4;
  localparam int PIN_N    = 8;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PULL_ENABLE_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] SLEW_ENABLE_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] DRIVE_SELECT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] PAD_STATUS_OFS   = 8'h0C;

  // ----------------------------------------------------------------
  // Reset values: pull-ups off, slew limiting off, low drive
  // ----------------------------------------------------------------
  localparam logic [PIN_N-1:0] PULL_ENABLE_RST  = 8'h00;
  localparam logic [PIN_N-1:0] SLEW_ENABLE_RST  = 8'h00;
  localparam logic [PIN_N-1:0] DRIVE_SELECT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Pad status field positions (low bit of each byte field)
  // ----------------------------------------------------------------
  localparam int STAT_PULL_LSB  = 0;
  localparam int STAT_SLEW_LSB  = 8;
  localparam int STAT_DRIVE_LSB = 16;
  localparam int STAT_DIR_LSB   = 24;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic DIR_OUTPUT   = 1'b1;
  localparam logic DRIVE_HIGH   = 1'b1;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

endpackage

/* pcp_pad_cell.sv */
// One pin's pad gating: direction decides which settings reach the pad
`timescale 1ns/1ps
`default_nettype none

module pcp_pad_cell (
  // Direction of the pin
  input  wire logic dir_in,
  // Software settings for the pin
  input  wire logic pull_enable_in,
  input  wire logic slew_enable_in,
  input  wire logic drive_strength_in,
  // Effective pad controls
  output logic      pull_up_on_out,
  output logic      slew_limit_on_out,
  output logic      high_drive_on_out
);

  logic is_output;

  assign is_output = (dir_in == pcp_pkg::DIR_OUTPUT); // RQ7

  // Pull-up only on inputs; an output forces it off
  assign pull_up_on_out    = pull_enable_in & ~is_output; // RQ2 RQ3

  // Slew and drive only matter while the driver is on
  assign slew_limit_on_out = slew_enable_in & is_output; // RQ4 RQ6
  assign high_drive_on_out =
    (drive_strength_in == pcp_pkg::DRIVE_HIGH) & is_output; // RQ8 RQ6

endmodule

`default_nettype wire

/* pcp_pad_ctrl.sv */
// Port C pad control registers with APB slave and per-pin pad gating
//
// Functional notes
// RQ1: Eight pull enable bits, one per pin, each switching that pin's pull-up.
// RQ2: Pull bit 1 on an input pin connects the pull-up; 0 leaves it off.
// RQ3: On an output pin the pull bit is ignored and pull-up is off.
// RQ4: Eight slew enable bits; set turns slew limiting on, clear turns off.
// RQ5: Eight drive strength bits, each choosing low or high drive per pin.
// RQ6: On input pins slew and drive strength bits have no effect.
// RQ7: Direction bit 1 makes the pin an output; 0 makes it input.
// RQ8: Drive strength bit 0 selects low drive, 1 selects high drive.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pcp_pad_ctrl (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  // APB slave
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [pcp_pkg::ADDR_W-1:0]  paddr_in,
  input  wire logic [pcp_pkg::DATA_W-1:0]  pwdata_in,
  input  wire logic [pcp_pkg::STRB_W-1:0]  pstrb_in,
  output logic      [pcp_pkg::DATA_W-1:0]  prdata_out,
  output logic                             pready_out,
  output logic                             pslverr_out,
  // Pin direction from the port's direction register
  input  wire logic [pcp_pkg::PIN_N-1:0]   direction_bits_in,
  // Pad controls towards the third port pins
  output logic      [pcp_pkg::PIN_N-1:0]   pull_up_on_out,
  output logic      [pcp_pkg::PIN_N-1:0]   slew_limit_on_out,
  output logic      [pcp_pkg::PIN_N-1:0]   high_drive_on_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [pcp_pkg::PIN_N-1:0]  pull_enable_bits;
    logic [pcp_pkg::PIN_N-1:0]  slew_enable_bits;
    logic [pcp_pkg::PIN_N-1:0]  drive_strength_bits;
    logic [pcp_pkg::PIN_N-1:0]  pull_up_on;
    logic [pcp_pkg::PIN_N-1:0]  slew_limit_on;
    logic [pcp_pkg::PIN_N-1:0]  high_drive_on;
    logic [pcp_pkg::DATA_W-1:0] rdata;
  } pcp_state_s;

  pcp_state_s state_q;
  pcp_state_s state_d;

  logic [pcp_pkg::PIN_N-1:0] cell_pull;
  logic [pcp_pkg::PIN_N-1:0] cell_slew;
  logic [pcp_pkg::PIN_N-1:0] cell_drive;
  logic                      setup_phase;
  logic                      access_phase;
  logic                      addr_hit;
  logic                      wr_commit;
  logic [pcp_pkg::DATA_W-1:0] read_mux;

  // ----------------------------------------------------------------
  // Per-pin pad gating
  // ----------------------------------------------------------------
  for (genvar i = 0; i < pcp_pkg::PIN_N; i++) begin : g_pin
    pcp_pad_cell u_cell (
      .dir_in            (direction_bits_in[i]),
      .pull_enable_in    (state_q.pull_enable_bits[i]),
      .slew_enable_in    (state_q.slew_enable_bits[i]),
      .drive_strength_in (state_q.drive_strength_bits[i]),
      .pull_up_on_out    (cell_pull[i]),
      .slew_limit_on_out (cell_slew[i]),
      .high_drive_on_out (cell_drive[i])
    );
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup_phase  = psel_in & ~penable_in;
  assign access_phase = psel_in & penable_in;

  always_comb begin
    addr_hit = 1'b1;
    read_mux = pcp_pkg::READ_ZERO;
    case (paddr_in)
      pcp_pkg::PULL_ENABLE_OFS: begin
        read_mux[pcp_pkg::PIN_N-1:0] = state_q.pull_enable_bits;
      end
      pcp_pkg::SLEW_ENABLE_OFS: begin
        read_mux[pcp_pkg::PIN_N-1:0] = state_q.slew_enable_bits;
      end
      pcp_pkg::DRIVE_SELECT_OFS: begin
        read_mux[pcp_pkg::PIN_N-1:0] = state_q.drive_strength_bits;
      end
      pcp_pkg::PAD_STATUS_OFS: begin
        // Shows what each pad is really doing, after direction gating
        read_mux[pcp_pkg::STAT_PULL_LSB +: pcp_pkg::PIN_N] =
          state_q.pull_up_on;
        read_mux[pcp_pkg::STAT_SLEW_LSB +: pcp_pkg::PIN_N] =
          state_q.slew_limit_on;
        read_mux[pcp_pkg::STAT_DRIVE_LSB +: pcp_pkg::PIN_N] =
          state_q.high_drive_on;
        read_mux[pcp_pkg::STAT_DIR_LSB +: pcp_pkg::PIN_N] =
          direction_bits_in;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready_out  = 1'b1;
  assign pslverr_out = access_phase & ~addr_hit;

  // Only lane 0 carries register data; other lanes are ignored
  assign wr_commit = access_phase & pwrite_in & addr_hit & pstrb_in[0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (wr_commit) begin
      case (paddr_in)
        pcp_pkg::PULL_ENABLE_OFS: begin
          state_d.pull_enable_bits = pwdata_in[pcp_pkg::PIN_N-1:0]; // RQ1
        end
        pcp_pkg::SLEW_ENABLE_OFS: begin
          state_d.slew_enable_bits = pwdata_in[pcp_pkg::PIN_N-1:0]; // RQ4
        end
        pcp_pkg::DRIVE_SELECT_OFS: begin
          state_d.drive_strength_bits =
            pwdata_in[pcp_pkg::PIN_N-1:0]; // RQ5
        end
        default: begin
          state_d.rdata = state_q.rdata;
        end
      endcase
    end
    // Read data is captured in setup so it stands through the access
    if (setup_phase && !pwrite_in) begin
      state_d.rdata = read_mux;
    end
    // Pad outputs are registered, so they trail a direction change by a cycle
    state_d.pull_up_on    = cell_pull; // RQ2 RQ3
    state_d.slew_limit_on = cell_slew; // RQ6
    state_d.high_drive_on = cell_drive; // RQ6 RQ8
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q.pull_enable_bits    <= pcp_pkg::PULL_ENABLE_RST;
      state_q.slew_enable_bits    <= pcp_pkg::SLEW_ENABLE_RST;
      state_q.drive_strength_bits <= pcp_pkg::DRIVE_SELECT_RST;
      state_q.pull_up_on          <= 8'h00;
      state_q.slew_limit_on       <= 8'h00;
      state_q.high_drive_on       <= 8'h00;
      state_q.rdata               <= pcp_pkg::READ_ZERO;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata_out        = state_q.rdata;
  assign pull_up_on_out    = state_q.pull_up_on;
  assign slew_limit_on_out = state_q.slew_limit_on;
  assign high_drive_on_out = state_q.high_drive_on;

endmodule

`default_nettype wire

/* pcp_pad_ctrl_asserts.sv */
// Checker for the pad control register block
`timescale 1ns/1ps
`default_nettype none

module pcp_pad_ctrl_asserts (
  input wire logic                       clk_in,
  input wire logic                       rst_n_in,
  input wire logic                       psel_in,
  input wire logic                       penable_in,
  input wire logic                       pwrite_in,
  input wire logic [pcp_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [pcp_pkg::DATA_W-1:0] pwdata_in,
  input wire logic [pcp_pkg::STRB_W-1:0] pstrb_in,
  input wire logic [pcp_pkg::DATA_W-1:0] prdata_out,
  input wire logic                       pready_out,
  input wire logic                       pslverr_out,
  input wire logic [pcp_pkg::PIN_N-1:0]  direction_bits_in,
  input wire logic [pcp_pkg::PIN_N-1:0]  pull_up_on_out,
  input wire logic [pcp_pkg::PIN_N-1:0]  slew_limit_on_out,
  input wire logic [pcp_pkg::PIN_N-1:0]  high_drive_on_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic acc = psel_in && penable_in;
  wire logic wr  = acc && pwrite_in && pstrb_in[0];
  a_pull_write: assert property (wr && paddr_in == 8'h00 |-> ##2
    pull_up_on_out == ($past(pwdata_in[7:0], 2) & ~$past(direction_bits_in)))
    else $error("pull-up does not follow written value");
  a_slew_write: assert property (wr && paddr_in == 8'h04 |-> ##2
    slew_limit_on_out == ($past(pwdata_in[7:0], 2) & $past(direction_bits_in)))
    else $error("slew limit does not follow written value");
  a_drive_write: assert property (wr && paddr_in == 8'h08 |-> ##2
    high_drive_on_out == ($past(pwdata_in[7:0], 2) & $past(direction_bits_in)))
    else $error("drive strength does not follow written value");
  a_out_pull_off: assert property ((pull_up_on_out & $past(direction_bits_in)) == 8'h00)
    else $error("pull-up on an output pin");
  a_in_slew_off: assert property ((slew_limit_on_out & ~$past(direction_bits_in)) == 8'h00)
    else $error("slew limit on an input pin");
  a_in_drive_off: assert property ((high_drive_on_out & ~$past(direction_bits_in)) == 8'h00)
    else $error("high drive on an input pin");
  a_ready_access: assert property (acc |-> pready_out)
    else $error("no ready in access phase");
  a_err_unmapped: assert property (acc |-> pslverr_out == !(paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0C}))
    else $error("error response wrong for address");
endmodule

bind pcp_pad_ctrl pcp_pad_ctrl_asserts u_chk (.*);

`default_nettype wire

/* testbench.sv */
// Self-checking bench for the pad control register block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00, direction_bits_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [3:0] pstrb_in = 4'h0;
  logic pready_out, pslverr_out, err;
  logic [7:0] pull_up_on_out, slew_limit_on_out, high_drive_on_out;
  logic [7:0] dirs [4] = '{8'h00, 8'hFF, 8'h0F, 8'hF0};
  int errors = 0, compares = 0, cycles = 0;

  pcp_pad_ctrl dut (.*);

  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Setup then access; request held until pready seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w;
    paddr_in <= a; pwdata_in <= d; pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      $display("mismatch %0t no ready within limit", $time);
    end
    rd = prdata_out;
    err = pslverr_out;
  endtask

  task automatic idle(input int c);
    psel_in <= 1'b0; penable_in <= 1'b0;
    repeat (c) @(posedge clk_in);
  endtask

  task automatic pads(input logic [7:0] p, input logic [7:0] s, input logic [7:0] d);
    chk(pull_up_on_out, p, "pull-up pads");
    chk(slew_limit_on_out, s, "slew pads");
    chk(high_drive_on_out, d, "drive pads");
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(0, 8'h00, 0, 0); chk(rd, 32'h0, "pull reset");
    apb(0, 8'h04, 0, 0); chk(rd, 32'h0, "slew reset");
    apb(0, 8'h08, 0, 0); chk(rd, 32'h0, "drive reset");
    apb(1, 8'h00, 32'hFFFF_FFA5, 4'hF);
    apb(1, 8'h04, 32'h0000_003C, 4'h1);
    apb(1, 8'h08, 32'h0000_0096, 4'h1);
    apb(1, 8'h00, 32'h0000_0011, 4'h0);
    apb(0, 8'h00, 0, 0); chk(rd, 32'hA5, "pull readback");
    apb(0, 8'h04, 0, 0); chk(rd, 32'h3C, "slew readback");
    apb(0, 8'h08, 0, 0); chk(rd, 32'h96, "drive readback");
    apb(0, 8'h10, 0, 0); chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1, 8'h10, 32'h0000_00FF, 4'h1); chk({31'h0, err}, 32'h1, "unmapped write error");
    apb(1, 8'h0C, 32'h0000_00FF, 4'h1); chk({31'h0, err}, 32'h0, "status write error");
    apb(0, 8'h00, 0, 0); chk(rd, 32'hA5, "pull after stray writes");
    for (int i = 0; i < 4; i++) begin
      direction_bits_in <= dirs[i];
      idle(3);
      pads(8'hA5 & ~dirs[i], 8'h3C & dirs[i], 8'h96 & dirs[i]);
      apb(0, 8'h0C, 0, 0);
      chk(rd, {dirs[i], 8'h96 & dirs[i], 8'h3C & dirs[i], 8'hA5 & ~dirs[i]}, "status");
    end
    apb(1, 8'h00, 32'h0000_005A, 4'h1);
    apb(1, 8'h08, 32'h0000_0069, 4'h1);
    idle(3);
    pads(8'h0A, 8'h30, 8'h60);
    rst_n_in <= 1'b0;
    idle(2);
    rst_n_in <= 1'b1;
    idle(2);
    pads(8'h00, 8'h00, 8'h00);
    end_of_test();
  end
endmodule

`default_nettype wire
